//--- hdl/prbs_meas_ctrl.sv
// How it works
// RQ1: Measurement time field zero means ungated, counters run until stopped.
// RQ2: Ungated periodic results accumulate and refresh silently; host polls them.
// RQ3: Newly enabled lanes on either side get cleared, then count.
// RQ4: Disabling lanes stops counting and copies results to current and previous.
// RQ5: Without periodic capability, ungated current results refresh only on stop.
// RQ6: With periodic capability, current results refresh at the chosen interval.
// RQ7: Update select 0 means one second, 1 means five seconds.
// RQ8: Freeze release with global bit clear restarts only enabled lanes.
// RQ9: Freeze release with global bit set restarts all lanes on both sides.
// RQ10: Before a reset, results are copied to current and previous copies.
// RQ11: After reset current restarts, previous keeps the pre-reset counts.
// RQ12: Setting the freeze bit holds enabled counters readable in results.
// RQ13: Clearing the freeze bit resets enabled lanes on host and media.
// RQ14: Host may restart each side by toggling that side's enables.
// RQ15: One gate timer per side shared by all lanes.
// RQ16: In gated mode the global bit is ignored.
// RQ17: Gated enable resets that side's timer and lanes, then counting starts.
// RQ18: Gate expiry stops counting and publishes the period's results.
// RQ19: Each gate expiry raises that side's gate-complete flag.
// RQ20: Unread results are overwritten by the newest gating period.
// RQ21: Gated without periodic capability, results appear only at gate end.
// RQ22: Gated with periodic capability, current results refresh while gating.
// RQ23: Host restarts gating by toggling the enable registers.
// RQ24: Field codes 1..5 give 5,10,30,60,120 s; 7 custom; 0 ungated.
// RQ25: Second ticks come from the core clock and only advance while running.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
module prbs_meas_ctrl #(
    parameter int SEC_CYCLES = prbs_meas_pkg::ONE_SEC_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic [prbs_meas_pkg::LANES-1:0] host_err_in,
    input wire logic [prbs_meas_pkg::LANES-1:0] media_err_in
);
    import prbs_meas_pkg::*;

    typedef logic [CNT_W-1:0] cnt_t;
    localparam logic [27:0] SEC_LAST = 28'(SEC_CYCLES - 1);

    // Gate length in seconds; the reserved code falls back to the custom length
    function automatic logic [7:0] gate_len(input logic [2:0] mt, input logic [7:0] custom);
        unique case (mt)
            3'h1: gate_len = GATE_5S;
            3'h2: gate_len = GATE_10S;
            3'h3: gate_len = GATE_30S;
            3'h4: gate_len = GATE_60S;
            3'h5: gate_len = GATE_120S;
            default: gate_len = (custom == 8'h00) ? 8'h01 : custom;
        endcase
    endfunction

    function automatic logic is_reg(input logic [7:0] a);
        is_reg = (a <= STATUS_OFS) && (a[1:0] == 2'h0);
    endfunction

    // Bus-side state
    logic aw_got;
    logic w_got;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    // Registers
    logic [7:0] ctrl;
    logic [LANES-1:0] en [2];
    logic [LANES-1:0] en_q [2];
    logic [7:0] cfg;
    logic [7:0] custom_secs;
    logic [1:0] gate_flag;
    logic [4:0] res_sel;
    // Per-side timing state
    logic [27:0] presc [2];
    logic [7:0] secs [2];
    logic [2:0] upd_secs [2];
    logic expired [2];
    // Result copies
    cnt_t cur [2][LANES];
    cnt_t prev [2][LANES];
    logic [LANES-1:0][CNT_W-1:0] live [2];
    // Decoded events
    logic do_write;
    logic ctrl_wr;
    logic hold_pulse;
    logic release_pulse;
    logic gated;
    logic periodic_cap;
    logic [7:0] gate_secs;
    logic [2:0] upd_len;
    logic [LANES-1:0] rise [2];
    logic [LANES-1:0] fall [2];
    logic [LANES-1:0] clear_mask [2];
    logic [LANES-1:0] count_mask [2];
    logic running [2];
    logic sec_tick [2];
    logic expire [2];
    logic upd [2];
    logic [31:0] rd_value;
    logic rd_ok;

    assign do_write = aw_got && w_got;
    assign ctrl_wr = do_write && wr_addr == CTRL_OFS && wr_strb[0];
    assign gated = ctrl[MTIME_LSB+2:MTIME_LSB] != 3'h0; // RQ1
    assign periodic_cap = cfg[PERIODIC_CAP_BIT];
    assign gate_secs = gate_len(ctrl[MTIME_LSB+2:MTIME_LSB], custom_secs); // RQ24
    assign upd_len = ctrl[UPD_SEL_BIT] ? UPD_5S : UPD_1S; // RQ7

    // Freeze bit edges as written by software
    assign hold_pulse = ctrl_wr && wr_data[FREEZE_BIT] && !ctrl[FREEZE_BIT]; // RQ12
    assign release_pulse = ctrl_wr && !wr_data[FREEZE_BIT] && ctrl[FREEZE_BIT]; // RQ13

    // Per-side event decode; each side has one gate timer shared by all its lanes
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            rise[s] = en[s] & ~en_q[s]; // RQ14 RQ23
            fall[s] = en_q[s] & ~en[s];
            running[s] = (|en[s]) && !expired[s] && !ctrl[FREEZE_BIT]; // RQ15
            sec_tick[s] = running[s] && presc[s] == SEC_LAST; // RQ25
            expire[s] = gated && sec_tick[s] && (secs[s] + 8'h01) >= gate_secs; // RQ18
            upd[s] = periodic_cap && sec_tick[s] && !expire[s]
                && (upd_secs[s] + 3'h1) >= upd_len; // RQ6 RQ22
            count_mask[s] = running[s] ? en[s] : '0; // RQ4
            clear_mask[s] = rise[s]; // RQ3 RQ17
            if (release_pulse) begin
                // Global bit only widens the reset when ungated
                if (!gated && ctrl[GLOBAL_BIT]) begin
                    clear_mask[s] = '1; // RQ9
                end else begin
                    clear_mask[s] = rise[s] | en[s]; // RQ8 RQ16
                end
            end
        end
    end

    lane_err_bank host_bank (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(clear_mask[0]),
        .count_in(count_mask[0]),
        .err_in(host_err_in),
        .live_out(live[0])
    );

    lane_err_bank media_bank (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(clear_mask[1]),
        .count_in(count_mask[1]),
        .err_in(media_err_in),
        .live_out(live[1])
    );

    // Gate timer and update interval per side; stand still unless running
    always_ff @(posedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            if (rst_in || (|rise[s]) || release_pulse) begin
                presc[s] <= '0; // RQ17
                secs[s] <= '0;
                upd_secs[s] <= '0;
                expired[s] <= 1'b0;
            end else if (running[s]) begin
                presc[s] <= sec_tick[s] ? 28'h0 : presc[s] + 28'h1;
                if (sec_tick[s]) begin
                    secs[s] <= secs[s] + 8'h01;
                    upd_secs[s] <= upd[s] ? 3'h0 : upd_secs[s] + 3'h1;
                end
                if (expire[s]) begin
                    expired[s] <= 1'b1; // RQ18
                end
            end
        end
    end

    // Result copies; prev only moves on a stop, a freeze or a gate end
    always_ff @(posedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            for (int l = 0; l < LANES; l++) begin
                if (rst_in) begin
                    cur[s][l] <= '0;
                    prev[s][l] <= '0;
                end else begin
                    if (clear_mask[s][l] && periodic_cap) begin
                        cur[s][l] <= '0; // RQ11
                    end else if (fall[s][l] || expire[s] || upd[s]
                        || (hold_pulse && en[s][l])) begin
                        cur[s][l] <= live[s][l]; // RQ2 RQ5 RQ10 RQ21
                    end
                    if (fall[s][l] || expire[s] || (hold_pulse && en[s][l])) begin
                        prev[s][l] <= live[s][l]; // RQ10 RQ20
                    end
                end
            end
        end
    end

    // Enable history for edge detection
    always_ff @(posedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            en_q[s] <= rst_in ? '0 : en[s];
        end
    end

    // Software-written registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl <= CTRL_RST;
            en[0] <= '0;
            en[1] <= '0;
            cfg <= CFG_RST;
            custom_secs <= CUSTOM_RST;
            res_sel <= '0;
        end else if (do_write && wr_strb[0]) begin
            unique case (wr_addr)
                CTRL_OFS: ctrl <= wr_data[7:0];
                HOST_EN_OFS: en[0] <= wr_data[7:0];
                MEDIA_EN_OFS: en[1] <= wr_data[7:0];
                CFG_OFS: cfg <= {7'h00, wr_data[PERIODIC_CAP_BIT]};
                CUSTOM_OFS: custom_secs <= wr_data[7:0];
                RES_SEL_OFS: res_sel <= wr_data[4:0];
                default: ;
            endcase
        end
    end

    // Gate-complete flags clear on read; a same-cycle expiry wins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gate_flag <= 2'h0;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (expire[s]) begin
                    gate_flag[s] <= 1'b1; // RQ19
                end else if (arvalid_in && arready_out && araddr_in == FLAGS_OFS) begin
                    gate_flag[s] <= 1'b0;
                end
            end
        end
    end

    // Read mux
    always_comb begin
        rd_value = 32'h0;
        rd_ok = is_reg(araddr_in);
        unique case (araddr_in)
            CTRL_OFS: rd_value = {24'h0, ctrl};
            HOST_EN_OFS: rd_value = {24'h0, en[0]};
            MEDIA_EN_OFS: rd_value = {24'h0, en[1]};
            CFG_OFS: rd_value = {24'h0, cfg & ~(8'h01 << PER_LANE_CAP_BIT)};
            CUSTOM_OFS: rd_value = {24'h0, custom_secs};
            FLAGS_OFS: rd_value = {30'h0, gate_flag};
            RES_SEL_OFS: rd_value = {27'h0, res_sel};
            RESULT_OFS: rd_value = {16'h0, res_sel[SEL_PREV_BIT]
                ? prev[res_sel[SEL_SIDE_BIT]][res_sel[2:0]]
                : cur[res_sel[SEL_SIDE_BIT]][res_sel[2:0]]};
            STATUS_OFS: rd_value = {8'h00, secs[1], secs[0], 4'h0, expired[1], expired[0],
                running[1], running[0]};
            default: rd_value = 32'h0;
        endcase
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_got <= 1'b0;
            awready_out <= 1'b0;
            wr_addr <= 8'h00;
        end else if (awvalid_in && awready_out) begin
            aw_got <= 1'b1;
            awready_out <= 1'b0;
            wr_addr <= awaddr_in;
        end else if (do_write) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !bvalid_out) begin
            awready_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            w_got <= 1'b0;
            wready_out <= 1'b0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
        end else if (wvalid_in && wready_out) begin
            w_got <= 1'b1;
            wready_out <= 1'b0;
            wr_data <= wdata_in;
            wr_strb <= wstrb_in;
        end else if (do_write) begin
            w_got <= 1'b0;
        end else if (!w_got && !bvalid_out) begin
            wready_out <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bvalid_out <= 1'b0;
            bresp_out <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_out <= 1'b1;
            bresp_out <= is_reg(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready_in) begin
            bvalid_out <= 1'b0;
        end
    end

    // Read channel; data captured at the address handshake
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0;
            rresp_out <= RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            arready_out <= 1'b0;
            rvalid_out <= 1'b1;
            rdata_out <= rd_value;
            rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_out && rready_in) begin
            rvalid_out <= 1'b0;
        end else if (!rvalid_out) begin
            arready_out <= 1'b1;
        end
    end

    // Checks
    a_ungated_no_expiry: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1
        !gated |=> !$rose(expired[0]) && !$rose(expired[1]))
        else $error("gate expired while ungated");
    a_new_lane_clear: assert property (@(posedge clk_in) disable iff (rst_in) // RQ3
        rise[0][0] |=> live[0][0] == '0)
        else $error("newly enabled lane not cleared");
    a_stop_copies_cur: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
        fall[0][0] && !(clear_mask[0][0] && periodic_cap)
        |=> cur[0][0] == $past(live[0][0]) && prev[0][0] == $past(live[0][0]))
        else $error("stopped lane results not published");
    a_update_needs_cap: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
        !periodic_cap |-> !upd[0] && !upd[1])
        else $error("periodic refresh without capability");
    a_global_all_lanes: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
        release_pulse && !gated && ctrl[GLOBAL_BIT] |=> live[0] == '0 && live[1] == '0)
        else $error("global reset missed a lane");
    a_gated_ignores_global: assert property (@(posedge clk_in) disable iff (rst_in) // RQ16
        release_pulse && gated |-> (clear_mask[0] & ~(rise[0] | en[0])) == '0
        && (clear_mask[1] & ~(rise[1] | en[1])) == '0)
        else $error("global bit acted while gated");
    a_frozen_no_count: assert property (@(posedge clk_in) disable iff (rst_in) // RQ12
        ctrl[FREEZE_BIT] |-> count_mask[0] == '0 && count_mask[1] == '0)
        else $error("counting while frozen");
    a_enable_timer_zero: assert property (@(posedge clk_in) disable iff (rst_in) // RQ17
        |rise[1] |=> secs[1] == 8'h00 && presc[1] == 28'h0 && !expired[1])
        else $error("enable did not restart gate timer");
    a_expiry_stops_all: assert property (@(posedge clk_in) disable iff (rst_in) // RQ18
        expire[0] |=> count_mask[0] == '0 && prev[0][0] == $past(live[0][0]))
        else $error("gate expiry did not stop and publish");
    a_flag_on_expiry: assert property (@(posedge clk_in) disable iff (rst_in) // RQ19
        expire[0] |=> gate_flag[0])
        else $error("gate-complete flag not raised");
    a_tick_period: assert property (@(posedge clk_in) disable iff (rst_in) // RQ25
        sec_tick[0] |-> presc[0] == SEC_LAST && running[0])
        else $error("second tick outside running time");
endmodule // prbs_meas_ctrl

//--- hdl/prbs_meas_pkg.sv
package prbs_meas_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] HOST_EN_OFS = 8'h04;
    localparam logic [7:0] MEDIA_EN_OFS = 8'h08;
    localparam logic [7:0] CFG_OFS = 8'h0c;
    localparam logic [7:0] CUSTOM_OFS = 8'h10;
    localparam logic [7:0] FLAGS_OFS = 8'h14;
    localparam logic [7:0] RES_SEL_OFS = 8'h18;
    localparam logic [7:0] RESULT_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    // Control byte fields
    localparam int UPD_SEL_BIT = 0;
    localparam int MTIME_LSB = 1;
    localparam int FREEZE_BIT = 5;
    localparam int GLOBAL_BIT = 7;
    // Config fields
    localparam int PERIODIC_CAP_BIT = 0;
    localparam int PER_LANE_CAP_BIT = 1;
    // Result selector fields
    localparam int SEL_SIDE_BIT = 3;
    localparam int SEL_PREV_BIT = 4;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CUSTOM_RST = 8'h01;
    localparam logic [7:0] CFG_RST = 8'h01;
    // Geometry
    localparam int LANES = 8;
    localparam int CNT_W = 16;
    // Time base
    localparam longint SEC_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam int ONE_SEC_CYCLES = int'(SEC_NS / CLK_PERIOD_NS);
    // Gate lengths and update intervals in seconds
    localparam logic [7:0] GATE_5S = 8'h05;
    localparam logic [7:0] GATE_10S = 8'h0a;
    localparam logic [7:0] GATE_30S = 8'h1e;
    localparam logic [7:0] GATE_60S = 8'h3c;
    localparam logic [7:0] GATE_120S = 8'h78;
    localparam logic [2:0] UPD_1S = 3'h1;
    localparam logic [2:0] UPD_5S = 3'h5;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/lane_err_bank.sv
// Eight saturating per-lane error counters with clear and count masks
module lane_err_bank (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [prbs_meas_pkg::LANES-1:0] clear_in,
    input wire logic [prbs_meas_pkg::LANES-1:0] count_in,
    input wire logic [prbs_meas_pkg::LANES-1:0] err_in,
    output logic [prbs_meas_pkg::LANES-1:0][prbs_meas_pkg::CNT_W-1:0] live_out
);
    import prbs_meas_pkg::*;

    // Clear beats counting so a restart never carries an old error forward
    always_ff @(posedge clk_in) begin
        for (int l = 0; l < LANES; l++) begin
            if (rst_in || clear_in[l]) begin
                live_out[l] <= '0;
            end else if (count_in[l] && err_in[l] && live_out[l] != '1) begin
                live_out[l] <= live_out[l] + 1'b1; // Saturates, never wraps
            end
        end
    end
endmodule // lane_err_bank

//--- verif/err_source.sv
// Pattern checker stand-in: emits a burst of error pulses on the selected lanes
module err_source (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [7:0] host_mask_in,
    input wire logic [7:0] media_mask_in,
    input wire logic [7:0] burst_in,
    output logic [7:0] host_err_out,
    output logic [7:0] media_err_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    // Burst countdown; every active cycle is one error on each selected lane
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            left <= 8'h00;
        end else if (start_in) begin
            left <= burst_in;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // Lines stay low between bursts, as a clean checker would report
    assign host_err_out = (left != 8'h00) ? host_mask_in : 8'h00;
    assign media_err_out = (left != 8'h00) ? media_mask_in : 8'h00;
    assign busy_out = (left != 8'h00) | start_in;
endmodule // err_source

//--- verif/prbs_meas_ctrl_tb.sv
module prbs_meas_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import prbs_meas_pkg::*;
    localparam int SEC = 20;
    logic clk_in = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, hmask = 8'h00, mmask = 8'h00, burst = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic start = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [7:0] host_err, media_err;
    logic [7:0] codes [6] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h8e};
    logic [7:0] secs [6] = '{GATE_5S, GATE_10S, GATE_30S, GATE_60S, GATE_120S, 8'h03};
    int fails = 0;
    int checks = 0;
    // Small second so that gate lengths fit a short run
    prbs_meas_ctrl #(.SEC_CYCLES(SEC)) DUT (
        .clk_in(clk_in), .rst_in(rst),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
        .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
        .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
        .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
        .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
        .host_err_in(host_err), .media_err_in(media_err)
    );
    err_source errs (
        .clk_in(clk_in), .rst_in(rst), .start_in(start),
        .host_mask_in(hmask), .media_mask_in(mmask), .burst_in(burst),
        .host_err_out(host_err), .media_err_out(media_err), .busy_out(busy)
    );
    // 250 MHz core clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where ready is settled for the next rise
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int k;
        logic ah, wh, bh;
        k = 0;
        @(posedge clk_in);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, v};
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_in);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid & bready;
            resp = bresp;
            @(posedge clk_in);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
            k++;
        end while (!bh && k < 50);
        chk(32'(k >= 50), 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        logic ah, rh;
        k = 0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_in);
            ah = arvalid & arready;
            rh = rvalid & rready;
            d = rdata;
            resp = rresp;
            @(posedge clk_in);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
            k++;
        end while (!rh && k < 50);
        chk(32'(k >= 50), 32'h0);
    endtask
    // Select a result copy and compare it
    task automatic rres(input logic [7:0] sel, input logic [31:0] e);
        logic [31:0] d;
        wr(RES_SEL_OFS, sel);
        rd(RESULT_OFS, d);
        chk(d, e);
    endtask
    task automatic inj(input logic [7:0] h, input logic [7:0] m, input logic [7:0] n);
        int k;
        k = 0;
        @(posedge clk_in);
        hmask <= h;
        mmask <= m;
        burst <= n;
        start <= 1'b1;
        @(posedge clk_in);
        start <= 1'b0;
        do begin
            @(negedge clk_in);
            k++;
        end while (busy && k < 300);
    endtask
    // Hang guard, well beyond the longest gate sequence
    initial begin
        repeat (60000) @(posedge clk_in);
        chk(32'h1, 32'h0);
        final_report();
    end
    initial begin
        logic [31:0] d;
        int k;
        repeat (5) @(posedge clk_in);
        rst <= 1'b0;
        // Reset values, then unmapped accesses
        rd(CTRL_OFS, d);
        chk(d, {24'h0, CTRL_RST});
        rd(CFG_OFS, d);
        chk(d, {24'h0, CFG_RST});
        rd(CUSTOM_OFS, d);
        chk(d, {24'h0, CUSTOM_RST});
        rd(8'h24, d);
        chk({d[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(8'h24, 8'hff);
        chk(32'(resp), 32'(RESP_SLVERR));
        // Ungated with periodic refresh at one second
        wr(HOST_EN_OFS, 8'h05);
        inj(8'h01 | 8'h04, 8'h00, 8'h05);
        repeat (2 * SEC + 5) @(posedge clk_in);
        rres(8'h00, 32'h5);
        inj(8'h01, 8'h00, 8'h02);
        wr(HOST_EN_OFS, 8'h00);
        rres(8'h00, 32'h7);
        rres(8'h10, 32'h7);
        wr(HOST_EN_OFS, 8'h01);
        rres(8'h00, 32'h0);
        // Five second refresh interval
        wr(CTRL_OFS, 8'h01);
        wr(HOST_EN_OFS, 8'h00);
        wr(HOST_EN_OFS, 8'h01);
        inj(8'h01, 8'h00, 8'h02);
        repeat (2 * SEC + 5) @(posedge clk_in);
        rres(8'h00, 32'h0);
        repeat (4 * SEC - 10) @(posedge clk_in);
        rres(8'h00, 32'h2);
        // No periodic capability: current copy moves only on stop
        wr(CTRL_OFS, 8'h00);
        wr(CFG_OFS, 8'h00);
        wr(HOST_EN_OFS, 8'h00);
        wr(HOST_EN_OFS, 8'h01);
        inj(8'h01, 8'h00, 8'h03);
        repeat (2 * SEC + 5) @(posedge clk_in);
        rres(8'h00, 32'h2);
        wr(HOST_EN_OFS, 8'h00);
        rres(8'h00, 32'h3);
        wr(CFG_OFS, 8'h01);
        // Freeze and release on both sides; lane 2 stays disabled
        wr(HOST_EN_OFS, 8'h01);
        wr(MEDIA_EN_OFS, 8'h01);
        inj(8'h01, 8'h01, 8'h06);
        wr(CTRL_OFS, 8'h20);
        inj(8'h01, 8'h01, 8'h02);
        rres(8'h00, 32'h6);
        rres(8'h08, 32'h6);
        rres(8'h10, 32'h6);
        wr(CTRL_OFS, 8'h00);
        rres(8'h00, 32'h0);
        rres(8'h08, 32'h0);
        rres(8'h02, 32'h5);
        rres(8'h10, 32'h6);
        wr(CTRL_OFS, 8'ha0);
        wr(CTRL_OFS, 8'h80);
        rres(8'h02, 32'h0);
        wr(CTRL_OFS, 8'h00);
        wr(MEDIA_EN_OFS, 8'h00);
        // Gated runs over every length code; the last also sets the ignored global bit
        wr(CUSTOM_OFS, 8'h03);
        for (int i = 0; i < 6; i++) begin
            wr(CTRL_OFS, codes[i]);
            wr(HOST_EN_OFS, 8'h00);
            wr(HOST_EN_OFS, 8'h01);
            inj(8'h01, 8'h00, 8'(i + 1));
            k = 0;
            do begin
                rd(STATUS_OFS, d);
                k++;
            end while (d[2] !== 1'b1 && k < 1000);
            chk({20'h0, d[15:8], d[3:0]}, {20'h0, secs[i], 4'h4});
            inj(8'h01, 8'h00, 8'h04);
            rres(8'h00, 32'(i + 1));
            rd(FLAGS_OFS, d);
            chk(d, 32'h1);
            rd(FLAGS_OFS, d);
            chk(d, 32'h0);
        end
        // Gated release with the global bit set must leave the idle lane 2 alone
        wr(HOST_EN_OFS, 8'h05);
        inj(8'h04, 8'h00, 8'h02);
        wr(HOST_EN_OFS, 8'h01);
        wr(CTRL_OFS, 8'hae);
        wr(CTRL_OFS, 8'h8e);
        rres(8'h02, 32'h2);
        final_report();
    end
endmodule // prbs_meas_ctrl_tb
